// file: rtl/srp_startup_seq.sv
// Startup reset sequencer, PLL gating and I2C/SPI slave control port
`timescale 1ns/1ps
module srp_startup_seq
#(
  parameter logic [6:0] CHIP_ADDR       = srp_pkg::CHIP_ADDR_DEFAULT,
  parameter int         LOCK_MAX_CYCLES = srp_pkg::PLL_LOCK_MAX_TICKS,
  parameter int         MEM_DEPTH       = srp_pkg::RAM_DEPTH
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic [srp_pkg::NUM_POR-1:0]     por_ok_i,
  input  wire logic                            mclk_valid_i,
  input  wire logic                            pll_lock_i,
  input  wire logic                            boot_strap_pin_i,
  input  wire logic                            boot_done_i,
  input  wire logic                            slave_select_addr_pin_i,
  input  wire logic                            sclk_scl_i,
  input  wire logic                            mosi_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_n_o,
  output logic                                 miso_o,
  output logic                                 miso_oe_n_o,
  output logic [srp_pkg::NUM_SHIFTERS-1:0]     shifter_reset_n_o,
  output logic                                 core_reset_n_o,
  output logic                                 pll_clk_gate_o,
  output logic                                 rom_init_done_o,
  output logic                                 boot_start_o,
  output logic                                 pll_enable_o,
  output logic                                 pll_locked_o,
  output logic                                 core_halt_o,
  output logic                                 spi_mode_o
);
  import srp_pkg::*;

  localparam int        SYNC_W   = 12;
  localparam int        MAW      = $clog2(MEM_DEPTH);
  localparam int        LCW      = $clog2(LOCK_MAX_CYCLES);
  localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_MAX_CYCLES - 1);
  // Select, clock and SDA lines idle high, so their sync flops reset high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 12'hD00;

  // Address lies inside the PLL configuration window
  function automatic logic is_pll_cfg(input logic [15:0] a);
    return (a >= PLL_CONTROL_A_ADDR) && (a <= PLL_LOCKED_ADDR);
  endfunction

  // ==========================================================================
  // Reset release and input synchronisers
  logic [1:0]        rst_sync_ff;
  logic              rst_n;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Only the second stage is read by the logic below
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= SYNC_IDLE;
      sync_ff <= SYNC_IDLE;
    end
    else
    begin
      meta_ff <= {sda_i, slave_select_addr_pin_i, mosi_i, sclk_scl_i, boot_done_i,
                  boot_strap_pin_i, pll_lock_i, mclk_valid_i, por_ok_i};
      sync_ff <= meta_ff;
    end
  end

  logic [NUM_POR-1:0] por_s;
  logic mclk_s, lock_s, strap_s, bdone_s, sck_s, mosi_s, ss_s, sda_s;
  assign {sda_s, ss_s, mosi_s, sck_s, bdone_s, strap_s, lock_s, mclk_s, por_s} = sync_ff;

  // ==========================================================================
  // Power domain resets, ROM initialisation and boot
  logic [NUM_SHIFTERS-1:0] shift_ff, nxt_shift;
  logic       core_run_ff, nxt_core_run, gate_ff, nxt_gate;
  logic       run_d_ff, nxt_run_d, rom_done_ff, nxt_rom_done, boot_ff, nxt_boot;
  logic [3:0] rom_cnt_ff, nxt_rom_cnt;

  always_comb
  begin
    nxt_shift[SHIFT_IO]     = por_s[POR_IO] & por_s[POR_CORE];
    nxt_shift[SHIFT_PLL]    = por_s[POR_PLL] & por_s[POR_CORE];
    nxt_shift[SHIFT_ANALOG] = por_s[POR_ANALOG] & por_s[POR_CORE];
    // Core waits on the I/O shifter, all supplies and a live clock
    nxt_core_run = shift_ff[SHIFT_IO] & (&por_s) & mclk_s;
    nxt_gate     = por_s[POR_CORE] & shift_ff[SHIFT_PLL];
    nxt_rom_cnt  = core_run_ff ? (rom_done_ff ? rom_cnt_ff : rom_cnt_ff + 4'h1) : 4'h0;
    nxt_rom_done = core_run_ff & (rom_done_ff | (rom_cnt_ff == ROM_INIT_LINES - 4'h1));
    nxt_run_d    = core_run_ff;
    // Strap is caught on the release edge, not under reset
    if (!core_run_ff)
      nxt_boot = 1'b0;
    else if (!run_d_ff)
      nxt_boot = strap_s;
    else if (bdone_s)
      nxt_boot = 1'b0;
    else
      nxt_boot = boot_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff    <= '0;
      core_run_ff <= 1'b0;
      gate_ff     <= 1'b0;
      rom_cnt_ff  <= 4'h0;
      rom_done_ff <= 1'b0;
      run_d_ff    <= 1'b0;
      boot_ff     <= 1'b0;
    end
    else
    begin
      shift_ff    <= nxt_shift;
      core_run_ff <= nxt_core_run;
      gate_ff     <= nxt_gate;
      rom_cnt_ff  <= nxt_rom_cnt;
      rom_done_ff <= nxt_rom_done;
      run_d_ff    <= nxt_run_d;
      boot_ff     <= nxt_boot;
    end
  end

  // ==========================================================================
  // PLL lock tracking; the lock watchdog counts clk_i cycles
  logic [15:0]    pll_a_ff, pll_b_ff, pll_src_ff, pll_on_ff, halt_ff;
  logic           locked_ff, nxt_locked, pll_en, acquiring;
  logic [LCW-1:0] lock_cnt_ff, nxt_lock_cnt;

  assign pll_en    = pll_on_ff[PLL_ENABLE_BIT];
  assign acquiring = pll_en & ~locked_ff;

  always_comb
  begin
    nxt_lock_cnt = acquiring ? lock_cnt_ff + LCW'(1) : '0;
    // Lock never takes longer than the watchdog, and drops with enable
    nxt_locked = pll_en & (locked_ff | lock_s | (lock_cnt_ff == LOCK_LAST));
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end
    else
    begin
      lock_cnt_ff <= nxt_lock_cnt;
      locked_ff   <= nxt_locked;
    end
  end

  // ==========================================================================
  // Mode select: three select pulses switch the port to SPI for good
  logic       ss_prev_ff, spi_ff, nxt_spi, ss_rise, ss_fall;
  logic [1:0] pulses_ff, nxt_pulses;

  assign ss_rise = ss_s & ~ss_prev_ff;
  assign ss_fall = ~ss_s & ss_prev_ff;

  always_comb
  begin
    nxt_pulses = (ss_rise & ~spi_ff) ? pulses_ff + 2'h1 : pulses_ff;
    nxt_spi    = spi_ff | (ss_rise & (pulses_ff == SS_PULSES_FOR_SPI - 2'h1));
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ss_prev_ff <= 1'b1;
      pulses_ff  <= 2'h0;
      spi_ff     <= 1'b0;
    end
    else
    begin
      ss_prev_ff <= ss_s;
      pulses_ff  <= nxt_pulses;
      spi_ff     <= nxt_spi;
    end
  end

  // ==========================================================================
  // Serial byte engine and frame decoder shared by I2C and SPI
  srp_frame_t  state_ff, nxt_state;
  logic        sck_prev_ff, sda_prev_ff, rw_ff, nxt_rw, ack_ff, nxt_ack;
  logic        load_ff, nxt_load, out_ff, nxt_out, moe_n_ff, nxt_moe_n, soe_n_ff, nxt_soe_n;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [7:0]  sh_ff, nxt_sh, rx_byte;
  logic [15:0] addr_ff, nxt_addr, tx_ff, nxt_tx, rd_word, mem_rdata;
  logic [7:0]  hi_ff, nxt_hi;
  logic        sdi, sck_rise, sck_fall, f_begin, f_end, byte_stb, tx_phase;
  logic        port_ok, wr_stb, wr_ok, rd_ok, mem_we, in_ram;

  assign sdi      = spi_ff ? mosi_s : sda_s;
  assign sck_rise = sck_s & ~sck_prev_ff;
  assign sck_fall = ~sck_s & sck_prev_ff;
  assign rx_byte  = {sh_ff[6:0], sdi};
  assign tx_phase = rw_ff & ((state_ff == FR_DATA_HI) || (state_ff == FR_DATA_LO));
  // SPI frames follow select, I2C frames follow start and stop conditions
  assign f_begin  = spi_ff ? ss_fall : (sck_s & sck_prev_ff & sda_prev_ff & ~sda_s);
  assign f_end    = spi_ff ? ss_rise : (sck_s & sck_prev_ff & ~sda_prev_ff & sda_s);
  assign byte_stb = (state_ff != FR_IDLE) & sck_rise & (cnt_ff == BIT_LAST);
  assign wr_stb   = byte_stb & (state_ff == FR_DATA_LO) & ~rw_ff;
  assign in_ram   = (addr_ff[15:12] != REG_PAGE) && (addr_ff < 16'(MEM_DEPTH));

  // Port stays dark through ROM init, boot download and lock acquisition
  assign port_ok = rom_done_ff & ~boot_ff & ~acquiring;
  assign wr_ok   = port_ok & (is_pll_cfg(addr_ff) | (locked_ff & mclk_s));
  assign rd_ok   = port_ok & (is_pll_cfg(addr_ff) | locked_ff);
  assign mem_we  = wr_stb & wr_ok & in_ram;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_rw    = rw_ff;
    nxt_addr  = addr_ff;
    nxt_hi    = hi_ff;
    nxt_ack   = ack_ff;
    nxt_load  = 1'b0;
    nxt_tx    = load_ff ? rd_word : tx_ff;
    nxt_out   = out_ff;
    nxt_moe_n = moe_n_ff;
    nxt_soe_n = soe_n_ff;
    if (f_begin)
    begin
      nxt_state = FR_CHIP;
      nxt_cnt   = 4'h0;
      nxt_soe_n = 1'b1;
    end
    else if (f_end)
    begin
      nxt_state = FR_IDLE;
      nxt_moe_n = 1'b1;
      nxt_soe_n = 1'b1;
    end
    else if ((state_ff != FR_IDLE) && sck_rise)
    begin
      // The ninth I2C clock is the acknowledge slot
      nxt_sh  = rx_byte;
      nxt_cnt = (cnt_ff == BIT_ACK) ? 4'h0 : ((cnt_ff == BIT_LAST) ? (spi_ff ? 4'h0 : BIT_ACK) : cnt_ff + 4'h1);
      // A master NACK after a read word frees SDA, else the stop is never seen
      if (!spi_ff && tx_phase && (cnt_ff == BIT_ACK) && sdi)
        nxt_state = FR_IGNORE;
    end
    else if ((state_ff != FR_IDLE) && sck_fall)
    begin
      if (!spi_ff && (cnt_ff == BIT_ACK))
        nxt_soe_n = ~ack_ff;
      else if (tx_phase && !load_ff)
      begin
        nxt_out   = tx_ff[15];
        nxt_tx    = {tx_ff[14:0], 1'b0};
        nxt_moe_n = ~spi_ff;
        nxt_soe_n = spi_ff | tx_ff[15];
      end
      else
        nxt_soe_n = 1'b1;
    end
    // Chip byte, two subaddress bytes except on an I2C read, then 16-bit words with auto increment
    if (byte_stb)
    begin
      nxt_ack = 1'b1;
      case (state_ff)
        FR_CHIP:
        begin
          nxt_rw = rx_byte[0];
          if (!spi_ff && (rx_byte[7:1] != CHIP_ADDR))
          begin
            nxt_state = FR_IGNORE;
            nxt_ack   = 1'b0;
          end
          else if (!spi_ff && rx_byte[0])
          begin
            nxt_state = FR_DATA_HI;
            nxt_load  = 1'b1;
          end
          else
            nxt_state = FR_ADDR_HI;
        end
        FR_ADDR_HI: begin nxt_addr[15:8] = rx_byte; nxt_state = FR_ADDR_LO; end
        FR_ADDR_LO:
        begin
          nxt_addr[7:0] = rx_byte;
          nxt_state     = FR_DATA_HI;
          nxt_load      = rw_ff;
        end
        FR_DATA_HI:
        begin
          nxt_hi    = rx_byte;
          nxt_ack   = ~rw_ff;
          nxt_state = FR_DATA_LO;
        end
        FR_DATA_LO:
        begin
          nxt_ack   = ~rw_ff;
          nxt_addr  = addr_ff + 16'h1;
          nxt_state = FR_DATA_HI;
          nxt_load  = rw_ff;
        end
        FR_IGNORE: nxt_ack = 1'b0;
        default:   nxt_state = FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= FR_IDLE;
      sck_prev_ff <= 1'b1; // SCL idles high, so no false edge after reset
      sda_prev_ff <= 1'b1;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 16'h0000;
      hi_ff <= 8'h00;
      ack_ff <= 1'b0;
      load_ff <= 1'b0;
      tx_ff <= 16'h0000;
      out_ff <= 1'b0;
      moe_n_ff <= 1'b1;
      soe_n_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      sck_prev_ff <= sck_s;
      sda_prev_ff <= sda_s;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rw_ff <= nxt_rw;
      addr_ff <= nxt_addr;
      hi_ff <= nxt_hi;
      ack_ff <= nxt_ack;
      load_ff <= nxt_load;
      tx_ff <= nxt_tx;
      out_ff <= nxt_out;
      moe_n_ff <= nxt_moe_n;
      soe_n_ff <= nxt_soe_n;
    end
  end

  // ==========================================================================
  // Register file and memory; blocked reads return zero
  srp_word_mem #(.DATA_W(DATA_W), .DEPTH(MEM_DEPTH)) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .wr_en_i (mem_we),
    .addr_i  (mem_we ? addr_ff[MAW-1:0] : nxt_addr[MAW-1:0]),
    .wdata_i ({hi_ff, rx_byte}),
    .rdata_o (mem_rdata)
  );

  always_comb
  begin
    rd_word = 16'h0000;
    if (rd_ok)
    begin
      case (addr_ff)
        PLL_CONTROL_A_ADDR:    rd_word = pll_a_ff;
        PLL_CONTROL_B_ADDR:    rd_word = pll_b_ff;
        PLL_CLOCK_SOURCE_ADDR: rd_word = pll_src_ff;
        PLL_TURN_ON_ADDR:      rd_word = pll_on_ff;
        PLL_LOCKED_ADDR:       rd_word = 16'(locked_ff) << PLL_LOCK_BIT;
        CORE_HALT_ADDR:        rd_word = halt_ff;
        default:               rd_word = in_ram ? mem_rdata : 16'h0000;
      endcase
    end
  end

  // Writes land only when the access window allows them
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_a_ff   <= REG_RESET_VAL;
      pll_b_ff   <= REG_RESET_VAL;
      pll_src_ff <= REG_RESET_VAL;
      pll_on_ff  <= REG_RESET_VAL;
      halt_ff    <= REG_RESET_VAL;
    end
    else if (wr_stb && wr_ok)
    begin
      case (addr_ff)
        PLL_CONTROL_A_ADDR:    pll_a_ff   <= {hi_ff, rx_byte};
        PLL_CONTROL_B_ADDR:    pll_b_ff   <= {hi_ff, rx_byte};
        PLL_CLOCK_SOURCE_ADDR: pll_src_ff <= {hi_ff, rx_byte};
        PLL_TURN_ON_ADDR:      pll_on_ff  <= {hi_ff, rx_byte};
        CORE_HALT_ADDR:        halt_ff    <= {hi_ff, rx_byte};
        default:               halt_ff    <= halt_ff;
      endcase
    end
  end

  assign sda_o             = 1'b0;
  assign miso_o            = out_ff;
  assign miso_oe_n_o       = moe_n_ff;
  assign sda_oe_n_o        = soe_n_ff;
  assign shifter_reset_n_o = shift_ff;
  assign core_reset_n_o    = core_run_ff;
  assign pll_clk_gate_o    = gate_ff;
  assign rom_init_done_o   = rom_done_ff;
  assign boot_start_o      = boot_ff;
  assign pll_enable_o      = pll_on_ff[PLL_ENABLE_BIT];
  assign pll_locked_o      = locked_ff;
  assign core_halt_o       = halt_ff[CORE_HALT_BIT];
  assign spi_mode_o        = spi_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence rom_wait_s;
    !rom_done_ff [*8];
  endsequence

  core_after_io_a: assert property (!shift_ff[SHIFT_IO] |=> !core_run_ff)
    else $error("core left reset before io shifter");
  release_cond_a: assert property ($rose(core_run_ff) |-> $past(mclk_s) && $past(&por_s))
    else $error("core released without clock or supplies");
  pll_gate_a: assert property (gate_ff |-> $past(shift_ff[SHIFT_PLL]))
    else $error("clock passed to pll too early");
  rom_eight_a: assert property ($rose(core_run_ff) |-> rom_wait_s ##1 rom_done_ff)
    else $error("rom init not eight cycles");
  lock_bound_a: assert property (acquiring && lock_cnt_ff == LOCK_LAST |=> locked_ff)
    else $error("lock exceeded limit");
  lock_clear_a: assert property (!pll_en |=> !locked_ff)
    else $error("lock bit high while pll off");
  locking_write_a: assert property (wr_stb && acquiring
    |=> $stable({pll_a_ff, pll_b_ff, pll_src_ff, pll_on_ff, halt_ff}))
    else $error("write took effect while locking");
  ram_gate_a: assert property (mem_we |-> locked_ff && mclk_s)
    else $error("memory written before lock");
  spi_sticky_a: assert property (spi_ff |=> spi_ff)
    else $error("spi mode lost");
  spi_third_a: assert property ($rose(spi_ff) |-> $past(ss_rise) && $past(pulses_ff) == 2'h2)
    else $error("spi mode on wrong pulse");

endmodule // srp_startup_seq

// file: rtl/srp_pkg.sv
// Shared constants and types for the startup, reset and slave port block
package srp_pkg;

  // ==========================================================================
  // Register map of the slave control port
  localparam logic [15:0] PLL_CONTROL_A_ADDR    = 16'hF000;
  localparam logic [15:0] PLL_CONTROL_B_ADDR    = 16'hF001;
  localparam logic [15:0] PLL_CLOCK_SOURCE_ADDR = 16'hF002;
  localparam logic [15:0] PLL_TURN_ON_ADDR      = 16'hF003;
  localparam logic [15:0] PLL_LOCKED_ADDR       = 16'hF004;
  localparam logic [15:0] CORE_HALT_ADDR        = 16'hF400;
  localparam logic [3:0]  REG_PAGE              = 4'hF;
  localparam logic [15:0] REG_RESET_VAL         = 16'h0000;

  // ==========================================================================
  // Field positions
  localparam int PLL_ENABLE_BIT = 0;
  localparam int PLL_LOCK_BIT   = 0;
  localparam int CORE_HALT_BIT  = 0;

  // ==========================================================================
  // Supply domains and level shifter resets
  localparam int NUM_POR       = 4;
  localparam int NUM_SHIFTERS  = 3;
  localparam int POR_IO        = 0;
  localparam int POR_CORE      = 1;
  localparam int POR_PLL       = 2;
  localparam int POR_ANALOG    = 3;
  localparam int SHIFT_IO      = 0;
  localparam int SHIFT_PLL     = 1;
  localparam int SHIFT_ANALOG  = 2;

  // ==========================================================================
  // Timing counts and port settings
  localparam logic [3:0]  ROM_INIT_LINES     = 4'h8;
  localparam int          PLL_LOCK_MAX_TICKS = 32768;
  localparam logic [1:0]  SS_PULSES_FOR_SPI  = 2'h3;
  localparam logic [6:0]  CHIP_ADDR_DEFAULT  = 7'h3A; // Arbitrary value
  localparam int          DATA_W             = 16;
  localparam int          RAM_DEPTH          = 256;
  localparam logic [3:0]  BIT_LAST           = 4'h7;
  localparam logic [3:0]  BIT_ACK            = 4'h8;

  // ==========================================================================
  // Transaction phases of one slave port frame
  typedef enum logic [2:0] {
    FR_IDLE,
    FR_CHIP,
    FR_ADDR_HI,
    FR_ADDR_LO,
    FR_DATA_HI,
    FR_DATA_LO,
    FR_IGNORE
  } srp_frame_t;

endpackage

// file: rtl/srp_word_mem.sv
// Single port word memory with registered read data
`timescale 1ns/1ps
module srp_word_mem #(
  parameter int DATA_W = 16,
  parameter int DEPTH  = 256,
  parameter int AW     = $clog2(DEPTH)
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [DATA_W-1:0] rdata_ff;

  // ==========================================================================
  // Array has no reset so it maps onto plain RAM
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_ff[addr_i] <= wdata_i;
    end
  end

  // Read data is registered and defined from reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      rdata_ff <= mem_ff[addr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule // srp_word_mem

// file: sim/srp_host_model.sv
// Host controller model driving the slave control port pins
`timescale 1ns/1ps
module srp_host_model
  import srp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  input  wire logic miso_i,
  output logic      scl_o,
  output logic      sda_low_o,
  output logic      ss_o,
  output logic      mosi_o
);
  // ====
  // Level seen on the ninth clock of the last byte, low means acknowledged
  logic ack_seen;
  // Idle bus: clock high, data released to the pull-up, select high
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    ss_o      = 1'b1;
    mosi_o    = 1'b0;
  end
  // Half period of the 64 ns link clock
  task automatic hp();
    repeat (4) @(posedge clk_i);
  endtask
  // One byte MSB first plus the ninth clock; m is our own level on the ninth
  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      scl_o     <= 1'b0;
      sda_low_o <= ~d[i];
      hp();
      scl_o <= 1'b1;
      hp();
      q[i] = sda_i;
    end
    scl_o     <= 1'b0;
    sda_low_o <= ~m;
    hp();
    scl_o <= 1'b1;
    hp();
    ack_seen = sda_i;
  endtask
  // Start and stop conditions, data moving while the clock is high
  task automatic start();
    scl_o     <= 1'b1;
    sda_low_o <= 1'b0;
    hp();
    sda_low_o <= 1'b1;
    hp();
  endtask
  task automatic stop();
    scl_o     <= 1'b0;
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask
  // Chip byte, two subaddress bytes, then one word when wd is set
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic wd);
    logic [7:0] q;
    start();
    xbyte({CHIP_ADDR_DEFAULT, 1'b0}, 1'b1, q);
    xbyte(a[15:8], 1'b1, q);
    xbyte(a[7:0], 1'b1, q);
    if (wd)
    begin
      xbyte(d[15:8], 1'b1, q);
      xbyte(d[7:0], 1'b1, q);
    end
    stop();
  endtask
  // Current-address read after a subaddress-only frame; we ack the high byte
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    wr(a, 16'h0000, 1'b0);
    start();
    xbyte({CHIP_ADDR_DEFAULT, 1'b1}, 1'b1, d[15:8]);
    xbyte(8'hFF, 1'b0, d[15:8]);
    xbyte(8'hFF, 1'b1, d[7:0]);
    stop();
  endtask
  // Select pulses with low phases of four clocks so the synchroniser sees them
  task automatic ss_pulses(input int n);
    repeat (n)
    begin
      ss_o <= 1'b0;
      hp();
      ss_o <= 1'b1;
      hp();
    end
  endtask
  // SPI mode 0 read: 24 header bits out, then one word back on MISO
  task automatic spi_rd(input logic [15:0] a, output logic [15:0] d);
    logic [39:0] v;
    v = {CHIP_ADDR_DEFAULT, 1'b1, a, 16'h0000};
    scl_o <= 1'b0;
    ss_o  <= 1'b0;
    hp();
    for (int i = 39; i >= 0; i--)
    begin
      mosi_o <= v[i];
      scl_o  <= 1'b0;
      hp();
      scl_o <= 1'b1;
      hp();
      v[i] = miso_i;
    end
    d = v[15:0];
    scl_o <= 1'b0;
    hp();
    ss_o <= 1'b1;
    hp();
  endtask
endmodule // srp_host_model

// file: sim/srp_startup_seq_tb_top.sv
// Self-checking bench for the startup sequencer and slave port
`timescale 1ns/1ps
module srp_startup_seq_tb_top;
  import srp_pkg::*;
  localparam int LOCK_MAX = 1000;
  logic clk = 1'b0, rst_n = 1'b0, mv = 1'b0, lk = 1'b0, strap = 1'b1, bd = 1'b0;
  logic [3:0] por = 4'h0;
  logic scl, sda_low, ss, mosi, sda_oe_n, core_rn, gate, romd, boots, pen, plk, halt, spim;
  logic [2:0] shr;
  logic miso, moe_n;
  logic [15:0] q;
  int miscompares = 0;
  int checked = 0;
  int n;
  // Open-drain data line with pull-up
  wire sda_w = ~sda_low & sda_oe_n;
  always #4 clk = ~clk;
  // ====
  // Design and host
  srp_startup_seq #(.LOCK_MAX_CYCLES(LOCK_MAX)) u_srp_startup_seq (.clk_i(clk),
    .reset_n_i(rst_n), .por_ok_i(por), .mclk_valid_i(mv), .pll_lock_i(lk),
    .boot_strap_pin_i(strap), .boot_done_i(bd), .slave_select_addr_pin_i(ss),
    .sclk_scl_i(scl), .mosi_i(mosi), .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n),
    .miso_o(miso), .miso_oe_n_o(moe_n), .shifter_reset_n_o(shr), .core_reset_n_o(core_rn),
    .pll_clk_gate_o(gate), .rom_init_done_o(romd), .boot_start_o(boots),
    .pll_enable_o(pen), .pll_locked_o(plk), .core_halt_o(halt), .spi_mode_o(spim));
  srp_host_model u_srp_host_model (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(sda_low), .ss_o(ss), .mosi_o(mosi), .miso_i(miso));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // I/O supply comes up first, then the rest together; release waits for all of them and the clock
  task automatic t_power();
    por <= 4'h1;
    repeat (10) @(posedge clk);
    chk(core_rn, 1'b0);
    chk(gate, 1'b0);
    por <= 4'hF;
    repeat (10) @(posedge clk);
    chk(core_rn, 1'b0);
    chk(shr, 3'h7);
    mv <= 1'b1;
    n = 0;
    while (core_rn !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    chk(shr[SHIFT_IO], 1'b1);
    n = 0;
    while (romd !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    chk(n, 8);
    chk(gate, 1'b1);
    chk(boots, 1'b1);
    bd <= 1'b1;
    repeat (6) @(posedge clk);
    chk(boots, 1'b0);
    $display("power test done");
  endtask
  // Before lock only the PLL page answers; host writes PLL registers first
  task automatic t_prelock();
    u_srp_host_model.rd(PLL_LOCKED_ADDR, q);
    chk(q, 16'h0000);
    u_srp_host_model.wr(PLL_CONTROL_A_ADDR, 16'h1234, 1'b1);
    chk(u_srp_host_model.ack_seen, 1'b0);
    u_srp_host_model.rd(PLL_CONTROL_A_ADDR, q);
    chk(q, 16'h1234);
    u_srp_host_model.wr(16'h0010, 16'hA5A5, 1'b1);
    u_srp_host_model.rd(16'h0010, q);
    chk(q, 16'h0000);
    $display("prelock test done");
  endtask
  // Lock acquisition, dark port, then full access and lock timeout
  task automatic t_lock();
    u_srp_host_model.wr(PLL_TURN_ON_ADDR, 16'h0001, 1'b1);
    chk(pen, 1'b1);
    u_srp_host_model.wr(PLL_CONTROL_B_ADDR, 16'h00FF, 1'b1);
    chk(plk, 1'b0);
    lk <= 1'b1;
    repeat (6) @(posedge clk);
    chk(plk, 1'b1);
    u_srp_host_model.rd(PLL_CONTROL_B_ADDR, q);
    chk(q, 16'h0000);
    u_srp_host_model.rd(PLL_LOCKED_ADDR, q);
    chk(q, 16'h0001);
    u_srp_host_model.wr(16'h0010, 16'hA5A5, 1'b1);
    u_srp_host_model.rd(16'h0010, q);
    chk(q, 16'hA5A5);
    u_srp_host_model.wr(CORE_HALT_ADDR, 16'h0001, 1'b1);
    chk(halt, 1'b1);
    u_srp_host_model.wr(PLL_TURN_ON_ADDR, 16'h0000, 1'b1);
    lk <= 1'b0;
    chk(plk, 1'b0);
    u_srp_host_model.wr(PLL_TURN_ON_ADDR, 16'h0001, 1'b1);
    n = 0;
    while (plk !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    chk(n > LOCK_MAX - 40 && n <= LOCK_MAX, 1'b1);
    $display("lock test done");
  endtask
  // Mode select by three select rises, sticky until the next reset
  task automatic t_spi();
    chk(spim, 1'b0);
    u_srp_host_model.ss_pulses(2);
    repeat (4) @(posedge clk);
    chk(spim, 1'b0);
    u_srp_host_model.ss_pulses(1);
    repeat (4) @(posedge clk);
    chk(spim, 1'b1);
    u_srp_host_model.spi_rd(PLL_LOCKED_ADDR, q);
    chk(q, 16'h0001);
    chk(moe_n, 1'b1);
    u_srp_host_model.ss_pulses(3);
    chk(spim, 1'b1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(spim, 1'b0);
    $display("spi mode test done");
  endtask
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ====
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_power();
    t_prelock();
    t_lock();
    t_spi();
    give_verdict();
  end
  initial
  begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule // srp_startup_seq_tb_top
